// [hdl/scs_pkg.sv]
/*
 package for the strap sampling and access status block: register map, fields, reset values.
 assumes a single 20 MHz clock and a classic wishbone master with 32-bit data.
*/
// Contract
// - while the active-low chip reset input is low the block is held in reset; clk_out_o, contrast_current_out_o and the control register are not held by it.
// - a low clock source strap selects the crystal PLL, a high one selects the external crystal-in clock.
// - a low panel bus width strap selects a 4-bit panel bus, a high one an 8-bit panel bus.
// - a low host bus style strap selects 8080 strobes, a high one 6800 enable plus read/write.
// - in 8080 style a low host bus width strap gives a 4-bit host bus, a high one an 8-bit host bus.
// - during a host read the status pair is state0=1 state1=0, during a host write both are 1.
// - with no command received or a valid command read, state0 is low and state1 is don't-care.
// - the contrast current output is high impedance whenever the contrast dac is disabled.
// - the internal system clock is presented on the clock output pin.
package scs_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_STRAP   = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_ACCESS  = 8'h08;

	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_CLK_SRC   = 0;
	localparam int BIT_PANEL_W   = 1;
	localparam int BIT_HOST_STY  = 2;
	localparam int BIT_HOST_W    = 3;
	localparam int BIT_TEST_MODE = 4;
	localparam int BIT_DAC_EN    = 0;
	localparam int BIT_CLK_OE    = 1;
	localparam int BIT_CMD_READ  = 0;
	localparam int BIT_CMD_WRITE = 1;
	localparam int BIT_CMD_DONE  = 2;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [1:0] CONTROL_RST = 2'h2;

	typedef enum logic {CLK_SRC_PLL, CLK_SRC_EXT} scs_clk_src_t;
	typedef enum logic {HOST_8080, HOST_6800} scs_host_style_t;
	typedef enum {ACC_IDLE, ACC_READ, ACC_WRITE} scs_acc_state_t;

	typedef struct packed {
		logic            test_mode;
		logic            host_8bit;
		scs_host_style_t host_style;
		logic            panel_8bit;
		scs_clk_src_t    clk_src;
	} scs_straps_t;

endpackage

// [hdl/scs_top.sv]
/*
 strap sampling, configuration decode, access status pins, clock output and contrast output gating.
 assumes straps and host strobes come from pins (synchronised here) and a classic wishbone master.
*/
`timescale 1ns/1ps
module scs_top (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               chip_reset_n_i,
	input  wire logic               clock_source_strap_i,
	input  wire logic               panel_bus_width_strap_i,
	input  wire logic               host_bus_style_strap_i,
	input  wire logic               host_bus_width_strap_i,
	input  wire logic               test_mode_strap_i,
	input  wire logic               host_read_i,
	input  wire logic               host_write_i,
	input  wire logic               cmd_valid_read_i,
	input  wire logic               pll_clk_i,
	input  wire logic               crystal_in_i,
	input  wire logic               dac_out_i,
	input  wire logic               cyc_i,
	input  wire logic               stb_i,
	input  wire logic               we_i,
	input  wire logic [7:0]         adr_i,
	input  wire logic [3:0]         sel_i,
	input  wire logic [31:0]        dat_i,
	output logic      [31:0]        dat_o,
	output logic                    ack_o,
	output logic                    access_state0_o,
	output logic                    access_state1_o,
	output logic                    contrast_current_out_o,
	output logic                    contrast_current_oe_o,
	output logic                    clk_out_o,
	output logic                    use_ext_clock_o,
	output logic                    panel_bus_8bit_o,
	output logic                    host_6800_o,
	output logic                    host_bus_8bit_o
);

	// ****************************************
	// synchronisers
	// ****************************************
	logic [9:0] sync1;
	logic [9:0] sync2;
	logic       run;
	logic       run_q;
	scs_pkg::scs_straps_t straps;
	logic [1:0] control;
	scs_pkg::scs_acc_state_t acc;

	always_ff @(posedge clk_i) begin
		sync1 <= {dac_out_i, crystal_in_i, pll_clk_i, cmd_valid_read_i, host_write_i, host_read_i,
			test_mode_strap_i, host_bus_width_strap_i, host_bus_style_strap_i, clock_source_strap_i};
		sync2 <= sync1;
	end

	// panel strap kept out of the vector above for readability
	logic pw1;
	logic pw2;
	logic rn1;
	always_ff @(posedge clk_i) begin
		pw1 <= panel_bus_width_strap_i;
		pw2 <= pw1;
		rn1 <= chip_reset_n_i;
	end

	// ****************************************
	// chip reset
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run   <= 1'b0;
			run_q <= 1'b0;
		end else begin
			run   <= rn1;
			run_q <= run;
		end
	end

	// ****************************************
	// strap capture, only at release
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			straps <= '0;
		end else if (!run_q) begin
			// held frozen while running: changes are ignored
			straps.clk_src    <= scs_pkg::scs_clk_src_t'(sync2[0]);
			straps.panel_8bit <= pw2;
			straps.host_style <= scs_pkg::scs_host_style_t'(sync2[1]);
			straps.host_8bit  <= sync2[2];
			straps.test_mode  <= sync2[3];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !run) begin
			use_ext_clock_o  <= 1'b0;
			panel_bus_8bit_o <= 1'b0;
			host_6800_o      <= 1'b0;
			host_bus_8bit_o  <= 1'b0;
		end else begin
			use_ext_clock_o  <= straps.clk_src == scs_pkg::CLK_SRC_EXT;
			panel_bus_8bit_o <= straps.panel_8bit;
			host_6800_o      <= straps.host_style == scs_pkg::HOST_6800;
			// width strap only meaningful for 8080; 6800 runs 8-bit
			host_bus_8bit_o  <= straps.host_style == scs_pkg::HOST_6800 || straps.host_8bit;
		end
	end

	// ****************************************
	// access status
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i || !run) begin
			acc <= scs_pkg::ACC_IDLE;
		end else begin
			case (acc)
				scs_pkg::ACC_IDLE: begin
					if (sync2[5])
						acc <= scs_pkg::ACC_WRITE;
					else if (sync2[4])
						acc <= scs_pkg::ACC_READ;
				end
				scs_pkg::ACC_READ: begin
					// a write overrides a read still waiting for its valid command
					if (sync2[5])
						acc <= scs_pkg::ACC_WRITE;
					else if (sync2[6])
						acc <= scs_pkg::ACC_IDLE;
				end
				scs_pkg::ACC_WRITE: begin
					if (!sync2[5])
						acc <= scs_pkg::ACC_IDLE;
				end
				default: acc <= scs_pkg::ACC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !run) begin
			access_state0_o <= 1'b0;
			access_state1_o <= 1'b0;
		end else begin
			access_state0_o <= acc != scs_pkg::ACC_IDLE;
			access_state1_o <= acc == scs_pkg::ACC_WRITE;
		end
	end

	// ****************************************
	// clock out and contrast gating
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_out_o              <= 1'b0;
			contrast_current_out_o <= 1'b0;
			contrast_current_oe_o  <= 1'b0;
		end else begin
			// sampled copy: a true clock mux lives in the clock tree
			clk_out_o              <= control[scs_pkg::BIT_CLK_OE] &
				(straps.clk_src == scs_pkg::CLK_SRC_EXT ? sync2[8] : sync2[7]);
			contrast_current_out_o <= control[scs_pkg::BIT_DAC_EN] & sync2[9];
			contrast_current_oe_o  <= run && control[scs_pkg::BIT_DAC_EN];
		end
	end

	// ****************************************
	// wishbone slave
	// ****************************************
	logic req;
	assign req = cyc_i && stb_i && !ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control <= scs_pkg::CONTROL_RST;
		end else if (req && we_i && sel_i[0] && adr_i == scs_pkg::ADDR_CONTROL) begin
			control <= dat_i[1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= req;
			dat_o <= '0;
			if (req && !we_i) begin
				case (adr_i)
					scs_pkg::ADDR_STRAP:   dat_o <= {27'h000_0000, straps};
					scs_pkg::ADDR_CONTROL: dat_o <= {30'h0000_0000, control};
					scs_pkg::ADDR_ACCESS:  dat_o <= {29'h0000_0000, run, access_state1_o, access_state0_o};
					default:               dat_o <= '0;
				endcase
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	chk_write_status: assert property (@(posedge clk_i) disable iff (rst_i)
		acc == scs_pkg::ACC_WRITE && run |=> access_state0_o && access_state1_o)
		else $error("write status wrong");
	chk_read_status: assert property (@(posedge clk_i) disable iff (rst_i)
		acc == scs_pkg::ACC_READ && run |=> access_state0_o && !access_state1_o)
		else $error("read status wrong");
	chk_idle_status: assert property (@(posedge clk_i) disable iff (rst_i)
		acc == scs_pkg::ACC_IDLE |=> !access_state0_o)
		else $error("idle status wrong");
	chk_dac_tristate: assert property (@(posedge clk_i) disable iff (rst_i)
		!control[scs_pkg::BIT_DAC_EN] |=> !contrast_current_oe_o)
		else $error("dac driven while off");
	chk_straps_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
		run_q && $past(run_q) |-> $stable(straps))
		else $error("strap changed while running");
	chk_chip_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		!run |=> !access_state0_o && !host_6800_o)
		else $error("outputs active in reset");
	chk_host_style: assert property (@(posedge clk_i) disable iff (rst_i)
		run |=> host_6800_o == $past(straps.host_style == scs_pkg::HOST_6800))
		else $error("host style wrong");
	chk_clock_src: assert property (@(posedge clk_i) disable iff (rst_i)
		run |=> use_ext_clock_o == $past(straps.clk_src == scs_pkg::CLK_SRC_EXT))
		else $error("clock source wrong");
	chk_bus_widths: assert property (@(posedge clk_i) disable iff (rst_i)
		run && straps.host_style == scs_pkg::HOST_8080 |=> host_bus_8bit_o == $past(straps.host_8bit)
		&& panel_bus_8bit_o == $past(straps.panel_8bit))
		else $error("bus width wrong");
	chk_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held");

endmodule

// [verification/scs_host_model.sv]
/*
 host side model: access strobes and the test strap.
 assumes the bench picks one op code per cycle.
*/
`timescale 1ns/1ps
module scs_host_model (
	input  wire logic [1:0] op_i,
	input  wire logic       host_8bit_i,
	output logic            host_read_o,
	output logic            host_write_o,
	output logic            cmd_valid_read_o,
	output logic            test_mode_strap_o,
	output logic            data_hi_oe_o
);
	// ****************
	// pin drive
	// ****************
	// test strap never moves: a low value is not normal use
	assign test_mode_strap_o = 1'b1;
	assign host_read_o       = (op_i == 2'h1);
	assign host_write_o      = (op_i == 2'h2);
	assign cmd_valid_read_o  = (op_i == 2'h3);
	// upper data nibble left floating on a 4-bit host bus
	assign data_hi_oe_o      = host_8bit_i;
endmodule

// [verification/testbench.sv]
/*
 bench: straps, access status, contrast and clock out via wishbone.
 assumes a one cycle ack and registered outputs.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
	logic                clk_i, rst_i, rst_n, req, we, pll, xtal, dac;
	logic [1:0]          op;
	logic [7:0]          adr;
	logic [31:0]         dat, dat_o, q;
	logic                ack_o, s0, s1, oe, cout, ck, ext, p8, h68, h8, rd, wr, vr, tm, hoe;
	scs_pkg::scs_straps_t st;
	int                  errors, num_checks, cnt;

	scs_host_model host (.op_i(op), .host_8bit_i(h8), .host_read_o(rd), .host_write_o(wr),
		.cmd_valid_read_o(vr), .test_mode_strap_o(tm), .data_hi_oe_o(hoe));
	scs_top dut (.clk_i(clk_i), .rst_i(rst_i), .chip_reset_n_i(rst_n),
		.clock_source_strap_i(st.clk_src), .panel_bus_width_strap_i(st.panel_8bit),
		.host_bus_style_strap_i(st.host_style), .host_bus_width_strap_i(st.host_8bit),
		.test_mode_strap_i(tm), .host_read_i(rd), .host_write_i(wr), .cmd_valid_read_i(vr),
		.pll_clk_i(pll), .crystal_in_i(xtal), .dac_out_i(dac), .cyc_i(req), .stb_i(req),
		.we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.access_state0_o(s0), .access_state1_o(s1), .contrast_current_out_o(cout),
		.contrast_current_oe_o(oe), .clk_out_o(ck), .use_ext_clock_o(ext),
		.panel_bus_8bit_o(p8), .host_6800_o(h68), .host_bus_8bit_o(h8));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task finish_test;
		if (errors == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ****************
	// bus access, ack sampled before the edge's own updates
	// ****************
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		req <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		// only the bench timeout ends a hung wait
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o;
		req <= 1'b0;
		@(posedge clk_i);
	endtask

	task cfg(input logic [3:0] s);
		rst_n <= 1'b0;
		st <= {1'b0, s};
		repeat (4) @(posedge clk_i);
		`CHK({h8, h68, p8, ext}, 4'h0)
		rst_n <= 1'b1;
		repeat (6) @(posedge clk_i);
		st <= {1'b0, ~s};
		repeat (4) @(posedge clk_i);
		wb(1'b0, scs_pkg::ADDR_STRAP, 32'h0);
		`CHK(q, {27'h0, 1'b1, s})
		`CHK({h8, h68, p8, ext}, {s[3] | s[2], s[2:0]})
	endtask

	always @(posedge clk_i) begin
		cnt++;
		if (cnt == 3000) begin
			errors++;
			finish_test();
		end
	end

	// ****************
	// main sequence
	// ****************
	initial begin
		{rst_i, rst_n, req, we, pll, xtal, dac, op, adr, dat, st} = '0;
		{errors, num_checks, cnt} = '0;
		rst_i = 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		cfg(4'hA);
		cfg(4'h1);
		xtal <= 1'b1;
		repeat (6) @(posedge clk_i);
		`CHK(ck, 1'b1)
		`CHK(hoe, 1'b0)
		xtal <= 1'b0;
		cfg(4'h4);
		cfg(4'hC);
		`CHK(s0, 1'b0)
		for (int i = 1; i < 4; i++) begin
			op <= i[1:0];
			repeat (6) @(posedge clk_i);
			`CHK({s0, s1 | (i == 3)}, (i == 3) ? 2'b01 : {1'b1, i == 2})
		end
		op <= 2'h1;
		repeat (6) @(posedge clk_i);
		op <= 2'h3;
		repeat (6) @(posedge clk_i);
		`CHK(s0, 1'b0)
		op <= 2'h2;
		repeat (6) @(posedge clk_i);
		wb(1'b0, scs_pkg::ADDR_ACCESS, 32'h0);
		`CHK(q, 32'h0000_0007)
		op <= 2'h0;
		wb(1'b0, scs_pkg::ADDR_CONTROL, 32'h0);
		`CHK(q, 32'h0000_0002)
		pll <= 1'b1;
		repeat (6) @(posedge clk_i);
		`CHK(ck, 1'b1)
		pll <= 1'b0;
		repeat (6) @(posedge clk_i);
		`CHK(ck, 1'b0)
		// dac on with clock output gated off
		dac <= 1'b1;
		pll <= 1'b1;
		wb(1'b1, scs_pkg::ADDR_CONTROL, 32'h0000_0001);
		repeat (6) @(posedge clk_i);
		`CHK({oe, cout, ck}, 3'b110)
		wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
		wb(1'b0, 8'h0C, 32'h0);
		`CHK(q, 32'h0000_0000)
		wb(1'b1, scs_pkg::ADDR_CONTROL, 32'h0000_0000);
		repeat (4) @(posedge clk_i);
		`CHK(oe, 1'b0)
		finish_test();
	end
endmodule
